// *** cp0_regs_pkg.sv ***
// offsets, field positions, reset values and enumerations for the
// system-control register bank; assumes a 32-bit AXI4-Lite register port
package cp0_regs_pkg;

  localparam logic [7:0]  OFS_FAULT   = 8'h00;
  localparam logic [7:0]  OFS_BRANCH  = 8'h04;
  localparam logic [7:0]  OFS_COUNT   = 8'h08;
  localparam logic [7:0]  OFS_COMPARE = 8'h0C;
  localparam logic [7:0]  OFS_STATUS  = 8'h10;
  localparam logic [7:0]  OFS_CTRL    = 8'h14;

  localparam int B_IE    = 0;
  localparam int B_EXL   = 1;
  localparam int B_ERL   = 2;
  localparam int B_UM    = 4;
  localparam int B_IM_LO = 10;
  localparam int B_CEE   = 17;
  localparam int B_NMI   = 19;
  localparam int B_SR    = 20;
  localparam int B_RE    = 25;
  localparam int B_RP    = 27;
  localparam int B_CU0   = 28;

  // control register: counter_disable, debug_timer_run, presence bits
  localparam int C_DIS = 0;
  localparam int C_DTR = 1;
  localparam int C_BI  = 30;
  localparam int C_BP  = 31;

  localparam logic [31:0] ST_WMASK  = 32'h7A47FF17;
  localparam logic [31:0] ST_RST    = 32'h00400004;
  localparam logic [1:0]  CTRL_RST  = 2'h2;
  localparam logic [31:0] WORD_RST  = 32'h00000000;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    EXC_NONE, EXC_VALID, EXC_EXEC, EXC_ADDR, EXC_INTR, EXC_MCHK,
    EXC_BUS, EXC_CACHE, EXC_WATCH, EXC_DEBUG
  } exc_cls_t;

endpackage

// *** cp0_regs.sv ***
// fault capture, interval timer and processor state registers
// assumes pipeline signals on core_clk; hw_irq_pin is asynchronous
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps

// Operation
// - validity, execution or addressing exception loads the faulting word.
// - interrupts, nmi, machine check, bus, cache, watch, debug leave it.
// - without a valid word the captured value is whatever arrives.
// - a short faulting word sits in bits 15:0, upper half zero.
// - delay-slot fault loads the prior branch word, same classes.
// - outside delay slot branch word arbitrary; other exceptions keep it.
// - a short branch word sits in bits 15:0, upper half zero.
// - read-only presence bits report each capture register.
// - counter steps every second clock while not disabled.
// - a software write loads the counter.
// - debug_timer_run decides counting while in debug mode.
// - count equal compare raises timer irq until compare written.
// - compare never changes by itself and reads back.
// - accept interrupts only with enable set and level and debug clear.
// - debug, else user when base user and levels clear, else kernel.
// - unusable coprocessor access faults; coprocessor 0 usable in kernel.
// - reduced-power bit drives low_power_out; cleared only by cold reset. Here a status write also clears it.
// - swap bit reverses byte order in user mode only.
// - soft reset entry sets its flag, other entries clear it; software clears.
// - nmi entry sets its flag, other entries clear it; software clears.
// - custom instruction with enable clear raises unusable exception.
// - exception level set on exceptions other than reset, nmi, cache error, debug.
// - error level set on reset, soft reset, nmi, cache error; resets one.
// - global enable is the master enable for all interrupt sources.
// - base mode bit one selects user, zero selects kernel.
module cp0_regs
  import cp0_regs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        exc_take,
  input  wire exc_cls_t    exc_cls,
  input  wire logic [31:0] exc_word,
  input  wire logic        exc_word_short,
  input  wire logic        exc_in_delay,
  input  wire logic [31:0] br_word,
  input  wire logic        br_word_short,
  input  wire logic        soft_rst_entry,
  input  wire logic        nmi_entry,
  input  wire logic        debug_flag,
  input  wire logic [5:0]  hw_irq_pin,
  input  wire logic        cop_req,
  input  wire logic [1:0]  cop_num,
  input  wire logic        cx_req,
  output logic             timer_irq_out,
  output logic             low_power_out,
  output logic             irq_accept,
  output logic             kernel_mode,
  output logic             user_mode,
  output logic             user_swap_active,
  output logic             cop_unusable,
  output logic             cx_unusable
);

  function automatic logic is_sync(input exc_cls_t c);
    return (c == EXC_VALID) || (c == EXC_EXEC) || (c == EXC_ADDR);
  endfunction

  function automatic logic [31:0] fit_word(input logic [31:0] w, input logic s);
    return s ? {16'h0000, w[15:0]} : w;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_CTRL);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0] fault_r;
  logic [31:0] branch_r;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [31:0] cmp_r;
  logic [31:0] cmp_nxt;
  logic [31:0] st_r;
  logic [31:0] st_nxt;
  logic [31:0] st_wr;
  logic [1:0]  ctrl_r;
  logic        half_r;
  logic [7:0]  waddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic [5:0]  irq_s1_r;
  logic [5:0]  irq_s2_r;
  logic        do_wr;
  logic        wr_cnt;
  logic        wr_cmp;
  logic        wr_st;
  logic        wr_ctrl;
  logic        inc;
  logic        tmatch;
  logic        lvl_clear;
  logic        kern;

  // ---------------- register bus ----------------
  assign do_wr   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_cnt  = do_wr && (waddr_r == OFS_COUNT);
  assign wr_cmp  = do_wr && (waddr_r == OFS_COMPARE);
  assign wr_st   = do_wr && (waddr_r == OFS_STATUS);
  assign wr_ctrl = do_wr && (waddr_r == OFS_CTRL);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      waddr_r       <= 8'h00;
      wdata_r       <= WORD_RST;
      wstrb_r       <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        waddr_r       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known(waddr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= WORD_RST;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_FAULT:   s_axi_rdata <= fault_r;
        OFS_BRANCH:  s_axi_rdata <= branch_r;
        OFS_COUNT:   s_axi_rdata <= cnt_r;
        OFS_COMPARE: s_axi_rdata <= cmp_r;
        OFS_STATUS:  s_axi_rdata <= st_r;
        OFS_CTRL:    s_axi_rdata <= {2'h3, 28'h0000000, ctrl_r};
        default:     s_axi_rdata <= WORD_RST;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- fault capture ----------------
  // no reset: contents are undefined until the first capture
  always_ff @(posedge core_clk)
  begin
    if (exc_take && is_sync(exc_cls))
    begin
      fault_r <= fit_word(exc_word, exc_word_short);
      if (exc_in_delay)
      begin
        branch_r <= fit_word(br_word, br_word_short);
      end
    end
  end

  // ---------------- interval timer ----------------
  assign inc = half_r && !ctrl_r[C_DIS] && (!debug_flag || ctrl_r[C_DTR]);

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (wr_cnt)
    begin
      cnt_nxt = merge(cnt_r, wdata_r, wstrb_r);
    end
    else if (inc)
    begin
      cnt_nxt = cnt_r + 32'h00000001;
    end
    cmp_nxt = wr_cmp ? merge(cmp_r, wdata_r, wstrb_r) : cmp_r;
  end

  // a match raised in the same cycle as a compare write wins over the clear
  assign tmatch = (wr_cnt || inc) && (cnt_nxt == cmp_nxt);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      half_r        <= 1'b0;
      cnt_r         <= WORD_RST;
      cmp_r         <= WORD_RST;
      timer_irq_out <= 1'b0;
      ctrl_r        <= CTRL_RST;
    end
    else
    begin
      half_r <= !half_r;
      cnt_r  <= cnt_nxt;
      cmp_r  <= cmp_nxt;
      if (tmatch)
      begin
        timer_irq_out <= 1'b1;
      end
      else if (wr_cmp)
      begin
        timer_irq_out <= 1'b0;
      end
      if (wr_ctrl && wstrb_r[0])
      begin
        ctrl_r <= wdata_r[1:0];
      end
    end
  end

  // ---------------- processor state ----------------
  assign st_wr = merge(st_r, wdata_r, wstrb_r);

  always_comb
  begin
    st_nxt = st_r;
    if (wr_st)
    begin
      st_nxt = (st_r & ~ST_WMASK) | (st_wr & ST_WMASK);
      st_nxt[B_SR]  = st_r[B_SR] & st_wr[B_SR];
      st_nxt[B_NMI] = st_r[B_NMI] & st_wr[B_NMI];
    end
    // hardware entries come after the software write so that they win
    if (soft_rst_entry || nmi_entry)
    begin
      st_nxt[B_SR]  = soft_rst_entry;
      st_nxt[B_NMI] = nmi_entry && !soft_rst_entry;
      st_nxt[B_ERL] = 1'b1;
    end
    else if (exc_take && exc_cls == EXC_CACHE)
    begin
      st_nxt[B_ERL] = 1'b1;
    end
    else if (exc_take && exc_cls != EXC_NONE && exc_cls != EXC_DEBUG)
    begin
      st_nxt[B_EXL] = 1'b1;
    end
  end

  // cold reset is the only reset here; it and a status write clear low_power_request
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= ST_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // pins are asynchronous; the first stage is read only by the second
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_s1_r <= 6'h00;
      irq_s2_r <= 6'h00;
    end
    else
    begin
      irq_s1_r <= hw_irq_pin;
      irq_s2_r <= irq_s1_r;
    end
  end

  assign lvl_clear = !st_r[B_EXL] && !st_r[B_ERL];
  assign kern      = !debug_flag && !(st_r[B_UM] && lvl_clear);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_power_out    <= 1'b0;
      irq_accept       <= 1'b0;
      kernel_mode      <= 1'b1;
      user_mode        <= 1'b0;
      user_swap_active <= 1'b0;
      cop_unusable     <= 1'b0;
      cx_unusable      <= 1'b0;
    end
    else
    begin
      low_power_out    <= st_r[B_RP];
      irq_accept       <= st_r[B_IE] && lvl_clear && !debug_flag
                          && |(irq_s2_r & st_r[B_IM_LO +: 6]);
      kernel_mode      <= kern;
      user_mode        <= !debug_flag && st_r[B_UM] && lvl_clear;
      user_swap_active <= !debug_flag && st_r[B_UM] && lvl_clear && st_r[B_RE];
      cop_unusable     <= cop_req && !st_r[B_CU0 + 32'(cop_num)]
                          && !(cop_num == 2'h0 && (kern || debug_flag));
      cx_unusable      <= cx_req && !st_r[B_CEE];
    end
  end

  // ---------------- checks ----------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_fault_cap;
    exc_take && is_sync(exc_cls) && !exc_word_short |=> fault_r == $past(exc_word);
  endproperty
  a_fault_cap: assert property (p_fault_cap) else $error("fault word not captured");

  property p_fault_keep;
    exc_take && !is_sync(exc_cls) |=> $stable(fault_r) && $stable(branch_r);
  endproperty
  a_fault_keep: assert property (p_fault_keep) else $error("capture changed");

  property p_fault_short;
    exc_take && is_sync(exc_cls) && exc_word_short
      |=> fault_r == {16'h0000, $past(exc_word[15:0])};
  endproperty
  a_fault_short: assert property (p_fault_short) else $error("short word bad");

  property p_branch_cap;
    exc_take && is_sync(exc_cls) && exc_in_delay
      |=> branch_r == ($past(br_word_short) ? {16'h0000, $past(br_word[15:0])}
                                             : $past(br_word));
  endproperty
  a_branch_cap: assert property (p_branch_cap) else $error("branch word bad");

  property p_count_step;
    !wr_cnt && !ctrl_r[C_DIS] && !debug_flag ##1 !wr_cnt && !ctrl_r[C_DIS] && !debug_flag
      |=> cnt_r == $past(cnt_r, 2) + 32'h00000001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count rate wrong");

  property p_count_load;
    wr_cnt && wstrb_r == 4'hF |=> cnt_r == $past(wdata_r);
  endproperty
  a_count_load: assert property (p_count_load) else $error("count not loaded");

  property p_irq_hold;
    timer_irq_out && !wr_cmp |=> timer_irq_out;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("timer irq dropped");

  property p_irq_clear;
    wr_cmp && !tmatch |=> !timer_irq_out;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("timer irq not cleared");

  property p_cmp_stable;
    !wr_cmp |=> $stable(cmp_r);
  endproperty
  a_cmp_stable: assert property (p_cmp_stable) else $error("compare moved");

  property p_low_power;
    ##1 low_power_out == $past(st_r[B_RP]);
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power mismatch");

  property p_soft_entry;
    soft_rst_entry |=> st_r[B_SR] && !st_r[B_NMI] && st_r[B_ERL];
  endproperty
  a_soft_entry: assert property (p_soft_entry) else $error("soft entry flags");

  property p_nmi_entry;
    nmi_entry && !soft_rst_entry |=> st_r[B_NMI] && !st_r[B_SR];
  endproperty
  a_nmi_entry: assert property (p_nmi_entry) else $error("nmi entry flags");

  property p_ro_zero;
    st_r[31] == 1'b0 && st_r[26] == 1'b0 && st_r[21] == 1'b0;
  endproperty
  a_ro_zero: assert property (p_ro_zero) else $error("read-only bit set");

  c_timer: cover property (!timer_irq_out ##1 timer_irq_out ##[1:50] wr_cmp);
  c_delay: cover property (exc_take && is_sync(exc_cls) && exc_in_delay);
  c_read:  cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_OKAY);
  c_accept: cover property (irq_accept);

endmodule // cp0_regs

// *** pipe_model.sv ***
// pipeline, exception and interrupt-pin model beside the register bank
// assumes the bench calls its tasks; every change follows a rising edge
`timescale 1ns/1ps
module pipe_model
  import cp0_regs_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   timer_irq_out,
  output exc_cls_t    exc_cls,
  output logic        exc_take,
  output logic [31:0] exc_word,
  output logic        exc_word_short,
  output logic        exc_in_delay,
  output logic [31:0] br_word,
  output logic        br_word_short,
  output logic        soft_rst_entry,
  output logic        nmi_entry,
  output logic [5:0]  hw_irq_pin,
  output logic        cop_req,
  output logic [1:0]  cop_num,
  output logic        cx_req
);
  // system loop: timer output returns on hardware input five
  assign hw_irq_pin = {timer_irq_out, 5'h00};

  initial
  begin
    exc_cls = EXC_NONE;
    {exc_take, exc_word, exc_word_short, exc_in_delay, br_word, br_word_short} = 68'h0;
    {soft_rst_entry, nmi_entry, cop_req, cop_num, cx_req} = 6'h00;
  end

  task automatic exc(input exc_cls_t c, input logic [31:0] w, input logic s,
                     input logic d, input logic [31:0] b, input logic bs);
    @(posedge core_clk);
    exc_cls <= c;
    {exc_take, exc_word, exc_word_short} <= {1'b1, w, s};
    {exc_in_delay, br_word, br_word_short} <= {d, b, bs};
    @(posedge core_clk);
    exc_cls <= EXC_NONE;
    // words are not held once the exception is gone
    {exc_take, exc_word, br_word} <= {1'b0, ~w, ~b};
  endtask

  // p: soft entry, nmi entry, coprocessor request, coprocessor number, custom
  task automatic pulse(input logic [5:0] p);
    @(posedge core_clk);
    {soft_rst_entry, nmi_entry, cop_req, cop_num, cx_req} <= p;
    @(posedge core_clk);
    {soft_rst_entry, nmi_entry, cop_req, cop_num, cx_req} <= {3'h0, ~p[2:1], 1'b0};
  endtask
endmodule // pipe_model

// *** cp0_fault_timer_status_tb.sv ***
// self-checking bench for the fault capture, timer and status registers
// assumes cp0_regs with pipe_model on its pipeline side; one 250 MHz clock
`timescale 1ns/1ps
module cp0_fault_timer_status_tb
  import cp0_regs_pkg::*;
;
  logic        core_clk, arst_n, debug_flag, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, exc_word, br_word, v, w;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, cop_num;
  logic        exc_take, exc_word_short, exc_in_delay, br_word_short;
  logic        soft_rst_entry, nmi_entry, cop_req, cx_req, timer_irq_out;
  logic        low_power_out, irq_accept, kernel_mode, user_mode;
  logic        user_swap_active, cop_unusable, cx_unusable;
  logic [5:0]  hw_irq_pin;
  exc_cls_t    exc_cls;
  int          bad_count, n_checks, cyc, t0;

  cp0_regs dut (
    .core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .exc_take, .exc_cls, .exc_word, .exc_word_short, .exc_in_delay, .br_word,
    .br_word_short, .soft_rst_entry, .nmi_entry, .debug_flag, .hw_irq_pin, .cop_req, .cop_num,
    .cx_req, .timer_irq_out, .low_power_out, .irq_accept, .kernel_mode, .user_mode,
    .user_swap_active, .cop_unusable, .cx_unusable
  );

  pipe_model pipe (
    .core_clk, .timer_irq_out, .exc_take, .exc_cls, .exc_word, .exc_word_short, .exc_in_delay,
    .br_word, .br_word_short, .soft_rst_entry, .nmi_entry, .hw_irq_pin, .cop_req, .cop_num,
    .cx_req
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ceiling far above the few hundred cycles the scenarios need
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // unmapped offsets answer with an error response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, a > OFS_CTRL ? RESP_SLVERR : RESP_OKAY);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    chk(s_axi_rresp, a > OFS_CTRL ? RESP_SLVERR : RESP_OKAY);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, w);
    chk(w, e);
  endtask

  task automatic t_reset();
    rc(OFS_STATUS, ST_RST);
    rc(OFS_CTRL, 32'hC0000002);
    chk({kernel_mode, low_power_out}, 2'h2);
    rc(8'h18, 32'h00000000);
    wr(8'h18, 32'hFFFFFFFF);
  endtask

  task automatic t_capture();
    wr(OFS_STATUS, 32'h00000000);
    pipe.exc(EXC_EXEC, 32'h0000002A, 1'b0, 1'b0, 32'h00000000, 1'b0);
    rc(OFS_FAULT, 32'h0000002A);
    rd(OFS_STATUS, v);
    chk(v[2:1], 2'h1);
    pipe.exc(EXC_VALID, 32'h12345678, 1'b0, 1'b1, 32'h9ABCDEF0, 1'b0);
    rc(OFS_FAULT, 32'h12345678);
    rc(OFS_BRANCH, 32'h9ABCDEF0);
    pipe.exc(EXC_ADDR, 32'hFFFF1234, 1'b1, 1'b1, 32'hFFFF5678, 1'b1);
    rc(OFS_FAULT, 32'h00001234);
    rc(OFS_BRANCH, 32'h00005678);
    // every asynchronous class must leave both words alone
    for (int i = 4; i < 10; i++)
    begin
      pipe.exc(exc_cls_t'(i), 32'h0BAD0BAD, 1'b0, 1'b1, 32'h0BAD0BAD, 1'b0);
      rc(OFS_FAULT, 32'h00001234);
      rc(OFS_BRANCH, 32'h00005678);
    end
    wr(OFS_STATUS, 32'h00000000);
    pipe.exc(EXC_CACHE, 32'h00000000, 1'b0, 1'b0, 32'h00000000, 1'b0);
    rd(OFS_STATUS, v);
    chk(v[2:1], 2'h2);
  endtask

  task automatic t_timer();
    wr(OFS_CTRL, 32'h00000003);
    wr(OFS_COUNT, 32'h00000100);
    rc(OFS_COUNT, 32'h00000100);
    wr(OFS_COMPARE, 32'h89ABCDEF);
    t0 = cyc;
    wr(OFS_CTRL, 32'h00000002);
    repeat (40) @(posedge core_clk);
    t0 = cyc - t0;
    wr(OFS_CTRL, 32'h00000003);
    rd(OFS_COUNT, v);
    chk(v - 32'h100 == t0 / 2 || v - 32'h100 == (t0 + 1) / 2, 1'b1);
    rc(OFS_COMPARE, 32'h89ABCDEF);
    @(posedge core_clk) debug_flag <= 1'b1;
    wr(OFS_CTRL, 32'h00000000);
    rd(OFS_COUNT, v);
    tick(20);
    rc(OFS_COUNT, v);
    wr(OFS_CTRL, 32'h00000002);
    tick(20);
    rd(OFS_COUNT, w);
    chk(w != v, 1'b1);
    @(posedge core_clk) debug_flag <= 1'b0;
    wr(OFS_CTRL, 32'h00000003);
    wr(OFS_COMPARE, 32'h00000010);
    wr(OFS_COUNT, 32'h0000000E);
    #1 chk(timer_irq_out, 1'b0);
    wr(OFS_CTRL, 32'h00000002);
    tick(12);
    chk(timer_irq_out, 1'b1);
    wr(OFS_STATUS, 32'h00008001);
    tick(4);
    chk(irq_accept, 1'b1);
    wr(OFS_STATUS, 32'h00008003);
    tick(2);
    chk(irq_accept, 1'b0);
    wr(OFS_STATUS, 32'h00008000);
    tick(2);
    chk({irq_accept, timer_irq_out}, 2'h1);
    wr(OFS_COMPARE, 32'h00000010);
    tick(2);
    chk(timer_irq_out, 1'b0);
    wr(OFS_CTRL, 32'h00000003);
    wr(OFS_COMPARE, 32'h00000001);
    wr(OFS_COUNT, 32'hFFFFFFFE);
    wr(OFS_CTRL, 32'h00000002);
    tick(10);
    rd(OFS_COUNT, v);
    chk({timer_irq_out, v < 32'h10}, 2'h3);
  endtask

  task automatic t_status();
    wr(OFS_STATUS, 32'hFFFFFFFF);
    rc(OFS_STATUS, ST_WMASK);
    tick(2);
    chk({low_power_out, kernel_mode}, 2'h3);
    wr(OFS_STATUS, 32'h02000010);
    tick(2);
    chk({user_mode, kernel_mode, user_swap_active}, 3'h5);
    pipe.pulse(6'b001000);
    #1 chk(cop_unusable, 1'b1);
    pipe.pulse(6'b000001);
    #1 chk(cx_unusable, 1'b1);
    @(posedge core_clk) debug_flag <= 1'b1;
    tick(2);
    chk({user_mode, user_swap_active}, 2'h0);
    @(posedge core_clk) debug_flag <= 1'b0;
    wr(OFS_STATUS, 32'h00020000);
    for (int n = 0; n < 4; n++)
    begin
      pipe.pulse({3'b001, n[1:0], 1'b0});
      #1 chk(cop_unusable, n != 0);
    end
    pipe.pulse(6'b000001);
    #1 chk(cx_unusable, 1'b0);
  endtask

  task automatic t_entry();
    wr(OFS_STATUS, 32'h08000000);
    pipe.pulse(6'b100000);
    rc(OFS_STATUS, 32'h08100004);
    wr(OFS_STATUS, 32'h08000000);
    rc(OFS_STATUS, 32'h08000000);
    pipe.pulse(6'b010000);
    rc(OFS_STATUS, 32'h08080004);
    wr(OFS_STATUS, 32'h08180000);
    rc(OFS_STATUS, 32'h08080000);
    wr(OFS_STATUS, 32'h08000000);
    rc(OFS_STATUS, 32'h08000000);
    #1 chk(low_power_out, 1'b1);
  endtask

  initial
  begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, debug_flag} = 53'h0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    t_capture();
    t_timer();
    t_status();
    t_entry();
    close_out();
  end
endmodule // cp0_fault_timer_status_tb
